// [rtl/tsr_pkg.sv]
// Purpose: Shared constants for the table-search refill support block.
// Assumes: Bit numbers in comments use big-endian order (bit 0 is the MSB).
// Notes:   Register numbers are special-register numbers seen by the core.
package tsr_pkg;
	// Special-register numbers of the table-search registers.
	localparam logic [9:0] SPR_DATA_MISS   = 10'h3F0;
	localparam logic [9:0] SPR_DATA_CMP    = 10'h3F1;
	localparam logic [9:0] SPR_PRIMARY     = 10'h3F2;
	localparam logic [9:0] SPR_SECONDARY   = 10'h3F3;
	localparam logic [9:0] SPR_INSTR_MISS  = 10'h3F4;
	localparam logic [9:0] SPR_INSTR_CMP   = 10'h3F5;
	localparam logic [9:0] SPR_STAGING     = 10'h3F6;
	localparam logic [9:0] SPR_SCRATCH0    = 10'h114;
	localparam int         SCRATCH_COUNT   = 4;
	// Configuration bit position, big-endian number and little-endian index.
	localparam int         SW_SEARCH_BIT   = 12;
	localparam int         SW_SEARCH_IDX   = 31 - SW_SEARCH_BIT;
	// Machine state bits: instruction and data translation enables.
	localparam int         MSR_IR_IDX      = 31 - 26;
	localparam int         MSR_DR_IDX      = 31 - 27;
	// Staging register writable mask: reserved bits 20-22 and 29 read zero.
	localparam logic [31:0] STAGING_MASK   = 32'hFFFF_F1FB;
	// Exception vector offsets.
	localparam logic [31:0] VEC_INSTR_MISS = 32'h0000_1000;
	localparam logic [31:0] VEC_LOAD_MISS  = 32'h0000_1100;
	localparam logic [31:0] VEC_STORE_MISS = 32'h0000_1200;
	// Kind of miss being reported.
	typedef enum logic [1:0] {
		MISS_INSTR,
		MISS_LOAD,
		MISS_STORE
	} tsr_miss_type;
endpackage

// [rtl/tsr_hash_if.sv]
// Purpose: Carries the miss address and table origin to the hash unit.
// Assumes: One clock; pure combinational result.
// Notes:   The hash unit returns both group addresses.
`timescale 1ns/100ps
interface tsr_hash_if;
	logic [31:0] missAddr;      // Effective address of the miss.
	logic [23:0] segmentId;     // Segment identifier for the hash.
	logic [31:0] descriptor;    // Table descriptor register.
	logic [31:0] primaryAddr;   // Primary group address.
	logic [31:0] secondaryAddr; // Secondary group address.
	modport core (output missAddr, output segmentId, output descriptor,
		input primaryAddr, input secondaryAddr);
	modport hasher (input missAddr, input segmentId, input descriptor,
		output primaryAddr, output secondaryAddr);
endinterface

// [rtl/tsr_hash_unit.sv]
// Purpose: Forms primary and secondary page-table-group addresses.
// Assumes: Hash is the plain segment/page-index exclusive-or, masked.
// Notes:   Only bits 7-25 differ between the two results.
`timescale 1ns/100ps
module tsr_hash_unit (
	// Hash connection.
	tsr_hash_if.hasher hb
);
	// Hash over the low segment bits and the page index.
	wire [18:0] hashValue = hb.segmentId[18:0] ^ {3'h0, hb.missAddr[27:12]};
	// Mask from the descriptor widens the used hash bits.
	wire [8:0]  hashMask  = hb.descriptor[8:0];
	wire [18:0] primHash  = {(hashValue[18:10] & hashMask) | hb.descriptor[24:16],
		hashValue[9:0]};
	wire [18:0] secHash   = {(~hashValue[18:10] & hashMask) | hb.descriptor[24:16],
		~hashValue[9:0]};

	// upper origin bits, group address, six zero bits.
	assign hb.primaryAddr   = {hb.descriptor[31:25], primHash, 6'h00};
	// secondary differs only in the hashed field.
	assign hb.secondaryAddr = {hb.descriptor[31:25], secHash, 6'h00};
endmodule // tsr_hash_unit

// [rtl/tsr_refill.sv]
// Purpose: Software table-search support registers for the MMU.
// Assumes: Core presents one-cycle miss, access and exception strobes.
// Notes:   Bit numbers in comments are big-endian; vectors are [31:0].
//
// Behaviour
// - Four supervisor scratch registers, always usable.
// - User access raises privileged program exception.
// - Every exception clears both translation enables.
// - Miss loads matching miss-address register, read-only.
// - Data miss address always captured big-endian.
// - Compare word: valid, segment id, clear, page index.
// - Load instruction writes compare and staging word.
// - Group address: origin, hash, six zero bits.
// - Group addresses read-only, derived from miss address.
// - Staging layout keeps reserved bits zero.
// - Entry selected by operand address and way bit.
// - Miss saves status, loads registers, takes exception.
// - Store hitting clean entry takes store miss.
// - Miss vectors are 0x1000, 0x1100, 0x1200.
// - Configuration bit 12 selects software search.
`timescale 1ns/100ps
module tsr_refill (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Special-register access from the core.
	input  wire logic        sprRead,
	input  wire logic        sprWrite,
	input  wire logic [9:0]  sprNum,
	input  wire logic [31:0] sprWdata,
	input  wire logic        userMode,
	output logic      [31:0] sprRdata,
	output logic             privTrap,
	// Miss report from the translation units.
	input  wire logic        missValid,
	input  wire logic        missIsInstr,
	input  wire logic        missIsStore,
	input  wire logic        storeHitClean,
	input  wire logic [31:0] missEa,
	input  wire logic        littleEndian,
	input  wire logic [23:0] segmentId,
	input  wire logic [31:0] descriptor,
	input  wire logic [3:0]  condField,
	input  wire logic        lruWay,
	// Machine state and configuration.
	input  wire logic        anyException,
	input  wire logic [31:0] stateIn,
	input  wire logic [31:0] configTwo,
	output logic      [31:0] stateOut,
	output logic      [31:0] statusSave,
	output logic             missTaken,
	output logic      [31:0] missVector,
	// TLB load instructions.
	input  wire logic        loadDataEntry,
	input  wire logic        loadInstrEntry,
	input  wire logic [31:0] loadEa,
	output logic             tlbWrite,
	output logic             tlbIsInstr,
	output logic [31:0]      tlbIndexEa,
	output logic             tlbWay,
	output logic [31:0]      tlbWordHi,
	output logic [31:0]      tlbWordLo
);
	// Stored state.
	logic [31:0] dataMiss_r;    // Data miss address.
	logic [31:0] instrMiss_r;   // Instruction miss address.
	logic [31:0] dataCmp_r;     // Data compare word.
	logic [31:0] instrCmp_r;    // Instruction compare word.
	logic [31:0] staging_r;     // Physical entry staging.
	logic [31:0] scratch_r [tsr_pkg::SCRATCH_COUNT]; // Supervisor scratch.
	logic        lastInstr_r;   // Which miss feeds the group addresses.
	logic [23:0] lastSeg_r;     // Segment id of the last miss.

	// Software search enabled by the configuration bit.
	// mode select
	wire swSearch = configTwo[tsr_pkg::SW_SEARCH_IDX];
	// store to a clean entry counts as a store miss.
	wire missEvent = swSearch & (missValid | storeHitClean);
	wire isInstr   = missIsInstr & missValid;
	// invert the low three address bits when the core runs little-endian.
	wire [31:0] dataEa = littleEndian ? {missEa[31:3], missEa[2:0] ^ 3'h7} : missEa;
	// compare word: V=1, segment id, H=0, page index bits.
	wire [31:0] cmpWord = {1'b1, segmentId, 1'b0, missEa[27:22]};

	// Hash unit connection.
	tsr_hash_if hif ();
	assign hif.missAddr   = lastInstr_r ? instrMiss_r : dataMiss_r;
	assign hif.segmentId  = lastSeg_r;
	assign hif.descriptor = descriptor;
	tsr_hash_unit uHash (
		.hb (hif.hasher)
	);

	// Table-search register decode for the access check; the scratch decode is shared by read and access check.
	function automatic logic isSearchReg(input logic [9:0] n);
		return (n >= tsr_pkg::SPR_DATA_MISS) && (n <= tsr_pkg::SPR_STAGING);
	endfunction
	function automatic logic isScratch(input logic [9:0] n);
		return (n >= tsr_pkg::SPR_SCRATCH0) &&
			(n < tsr_pkg::SPR_SCRATCH0 + 10'(tsr_pkg::SCRATCH_COUNT));
	endfunction
	wire access    = sprRead | sprWrite;
	wire ours      = isSearchReg(sprNum) | isScratch(sprNum);
	// user-level access to these registers traps.
	wire trapNow   = access & ours & userMode;
	wire supWrite  = sprWrite & ~userMode;
	wire [1:0] scrIdx = 2'(sprNum - tsr_pkg::SPR_SCRATCH0);

	// Read selection; miss, compare and group registers are read-only.
	logic [31:0] readMux;
	always_comb begin
		readMux = 32'h0000_0000;
		unique case (sprNum)
			tsr_pkg::SPR_DATA_MISS:  readMux = dataMiss_r;
			tsr_pkg::SPR_INSTR_MISS: readMux = instrMiss_r;
			tsr_pkg::SPR_DATA_CMP:   readMux = dataCmp_r;
			tsr_pkg::SPR_INSTR_CMP:  readMux = instrCmp_r;
			// group addresses come straight from the hash unit.
			tsr_pkg::SPR_PRIMARY:    readMux = hif.primaryAddr;
			tsr_pkg::SPR_SECONDARY:  readMux = hif.secondaryAddr;
			tsr_pkg::SPR_STAGING:    readMux = staging_r;
			default: begin
				if (isScratch(sprNum)) begin
					readMux = scratch_r[scrIdx];
				end
			end
		endcase
	end

	// Miss capture and staging writes.
	// miss address load; software writes are ignored.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dataMiss_r  <= 32'h0000_0000;
			instrMiss_r <= 32'h0000_0000;
			dataCmp_r   <= 32'h0000_0000;
			instrCmp_r  <= 32'h0000_0000;
			lastInstr_r <= 1'b0;
			lastSeg_r   <= 24'h00_0000;
		end else if (missEvent) begin
			lastInstr_r <= isInstr;
			lastSeg_r   <= segmentId;
			if (isInstr) begin
				instrMiss_r <= missEa;
				instrCmp_r  <= cmpWord;
			end else begin
				dataMiss_r  <= dataEa;
				dataCmp_r   <= cmpWord;
			end
		end
	end

	// staging register keeps reserved bits at zero.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			staging_r <= 32'h0000_0000;
		end else if (supWrite && sprNum == tsr_pkg::SPR_STAGING) begin
			staging_r <= sprWdata & tsr_pkg::STAGING_MASK;
		end
	end

	// scratch registers work whether or not search is enabled.
	genvar g;
	generate
		for (g = 0; g < tsr_pkg::SCRATCH_COUNT; g++) begin : gScratch
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					scratch_r[g] <= 32'h0000_0000;
				end else if (supWrite && isScratch(sprNum) && scrIdx == 2'(g)) begin
					scratch_r[g] <= sprWdata;
				end
			end
		end
	endgenerate

	// Vector select by miss kind.
	// vector offsets
	wire [31:0] vecSel = isInstr ? tsr_pkg::VEC_INSTR_MISS :
		((missIsStore | storeHitClean) ? tsr_pkg::VEC_STORE_MISS : tsr_pkg::VEC_LOAD_MISS);
	// condition field, way, store flag, saved low state half.
	wire [31:0] statusWord = {condField, lruWay, missIsStore | storeHitClean,
		10'h000, stateIn[15:0]};
	// translation enables cleared on any exception.
	wire [31:0] stateCleared = stateIn & ~(32'h0000_0001 << tsr_pkg::MSR_IR_IDX)
		& ~(32'h0000_0001 << tsr_pkg::MSR_DR_IDX);
	wire exceptNow = anyException | missEvent | trapNow;
	wire loadNow   = loadDataEntry | loadInstrEntry;

	// Registered outputs toward the core and the TLB arrays.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sprRdata   <= 32'h0000_0000;
			privTrap   <= 1'b0;
			stateOut   <= 32'h0000_0000;
			statusSave <= 32'h0000_0000;
			missTaken  <= 1'b0;
			missVector <= 32'h0000_0000;
			tlbWrite   <= 1'b0;
			tlbIsInstr <= 1'b0;
			tlbIndexEa <= 32'h0000_0000;
			tlbWay     <= 1'b0;
			tlbWordHi  <= 32'h0000_0000;
			tlbWordLo  <= 32'h0000_0000;
		end else begin
			sprRdata  <= (sprRead && !userMode) ? readMux : 32'h0000_0000;
			privTrap  <= trapNow;
			stateOut  <= exceptNow ? stateCleared : stateIn;
			// save status and report the miss exception.
			missTaken <= missEvent;
			if (missEvent) begin
				statusSave <= statusWord;
				missVector <= vecSel;
			end
			// entry words; index from operand and saved way.
			tlbWrite   <= loadNow & ~userMode;
			tlbIsInstr <= loadInstrEntry;
			tlbIndexEa <= loadEa;
			tlbWay     <= statusSave[27];
			tlbWordHi  <= loadInstrEntry ? instrCmp_r : dataCmp_r;
			tlbWordLo  <= staging_r;
		end
	end
endmodule // tsr_refill

// [verif/tsr_refill_assertions.sv]
// Purpose: Port timing checks for the refill support block.
// Assumes: One clock; rst_n is asynchronous and active low.
// Notes:   Every answer lands exactly one cycle after its request.
`timescale 1ns/100ps
module tsr_refill_assertions (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Register access requests.
	input wire logic        sprRead,
	input wire logic        sprWrite,
	input wire logic        userMode,
	input wire logic [9:0]  sprNum,
	// Miss reports, machine state and configuration.
	input wire logic        missValid,
	input wire logic        missIsInstr,
	input wire logic        missIsStore,
	input wire logic        storeHitClean,
	input wire logic        anyException,
	input wire logic [31:0] configTwo,
	input wire logic [31:0] stateIn,
	// TLB load requests.
	input wire logic        loadDataEntry,
	input wire logic [31:0] loadEa,
	// Answers of the block, all watched only.
	input wire logic        privTrap,
	input wire logic        missTaken,
	input wire logic        tlbWrite,
	input wire logic        tlbIsInstr,
	input wire logic [31:0] sprRdata,
	input wire logic [31:0] stateOut,
	input wire logic [31:0] missVector,
	input wire logic [31:0] tlbIndexEa
);
	// A miss only counts while software search is enabled.
	wire cfgOn = configTwo[tsr_pkg::SW_SEARCH_IDX];
	wire missGo = missValid && cfgOn;
	// A user access to a table or scratch register must trap.
	wire tblReg = (sprNum >= 10'h3F0 && sprNum <= 10'h3F6);
	wire userHit = userMode && (sprRead || sprWrite) && (tblReg || sprNum[9:2] == 8'h45);
	// Cycles in which the state copy must pass through untouched.
	wire quiet = !anyException && !missValid && !storeHitClean && !userHit;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_user_trap: assert property (
		userHit |=> privTrap) else $error("User access did not trap.");
	a_user_zero: assert property (
		sprRead && userMode |=> sprRdata == 32'h0000_0000) else $error("User read leaked.");
	a_miss_taken: assert property (
		missGo |=> missTaken) else $error("Miss not taken.");
	a_search_off: assert property (
		!cfgOn |=> !missTaken) else $error("Miss taken while disabled.");
	a_store_vector: assert property (
		cfgOn && (storeHitClean || missValid && missIsStore && !missIsInstr)
		|=> missVector == tsr_pkg::VEC_STORE_MISS) else $error("Bad store vector.");
	a_instr_vector: assert property (
		missGo && missIsInstr |=> missVector == tsr_pkg::VEC_INSTR_MISS) else $error("Bad vector.");
	a_state_clear: assert property (
		anyException || missGo |=> stateOut[5:4] == 2'b00) else $error("Enables kept.");
	a_state_copy: assert property (
		quiet |=> stateOut == $past(stateIn)) else $error("State copy wrong.");
	a_tlb_data: assert property (
		loadDataEntry && !userMode |=> tlbWrite && !tlbIsInstr && tlbIndexEa == $past(loadEa))
		else $error("Data entry load wrong.");
	c_data_miss: cover property (missGo && !missIsInstr);
	c_clean_hit: cover property (storeHitClean && cfgOn);
	c_user_trap: cover property (userHit);
	c_data_load: cover property (loadDataEntry && !userMode);
endmodule // tsr_refill_assertions
bind tsr_refill tsr_refill_assertions u_chk (.*);

// [verif/tsr_refill_test.sv]
// Purpose: Directed self-checking bench for the refill support block.
// Assumes: Inputs move at the falling edge; answers are read at the next falling edge.
// Notes:   Hash bits are checked only where the register layout fixes them.
`timescale 1ns/100ps
module tsr_refill_test;
	// Stimulus with time-zero values; most fields stay constant.
	logic        core_clk = 0, rst_n = 0, sprRead = 0, sprWrite = 0, userMode = 0;
	logic        missValid = 0, missIsInstr = 0, missIsStore = 0, storeHitClean = 0;
	logic        littleEndian = 0, lruWay = 1, anyException = 0;
	logic        loadDataEntry = 0, loadInstrEntry = 0;
	logic [9:0]  sprNum = 0;
	logic [23:0] segmentId = 24'hAB_CDEF;
	logic [3:0]  condField = 4'hA;
	logic [31:0] sprWdata = 0, missEa = 0, loadEa = 0, configTwo = 0;
	logic [31:0] descriptor = 32'hFE01_01FF, stateIn = 32'h1234_5678;
	// Answers of the block.
	logic        privTrap, missTaken, tlbWrite, tlbIsInstr, tlbWay;
	logic [31:0] sprRdata, stateOut, statusSave, missVector, tlbIndexEa, tlbWordHi, tlbWordLo;
	int          n_fail = 0, check_count = 0;
	logic [31:0] h1, cw;
	localparam logic [31:0] EA = 32'h1234_5000, IA = 32'h00AB_C000, PTE = 32'hABCD_E19A;
	tsr_refill DUT (.*);
	initial forever #2 core_clk = ~core_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One register access; read data is settled at the closing falling edge.
	task automatic spr(input logic wr, input logic [9:0] num, input logic [31:0] d);
		@(negedge core_clk);
		{sprWrite, sprRead, sprNum, sprWdata} = {wr, !wr, num, d};
		@(negedge core_clk);
		{sprWrite, sprRead} = 2'b00;
	endtask
	task automatic rd(input logic [9:0] num, input logic [31:0] exp);
		spr(0, num, 32'h0000_0000);
		check(sprRdata, exp);
	endtask
	// A miss report, or a store hit on a clean entry when c is set.
	task automatic miss(input logic i, input logic s, input logic c, input logic [31:0] ea);
		@(negedge core_clk);
		{missValid, storeHitClean, missIsInstr, missIsStore, missEa} = {!c, c, i, s, ea};
		@(negedge core_clk);
		{missValid, storeHitClean} = 2'b00;
	endtask
	task automatic ld(input logic i);
		@(negedge core_clk);
		{loadInstrEntry, loadDataEntry, loadEa} = {i, !i, 32'h0000_7000};
		@(negedge core_clk);
		{loadInstrEntry, loadDataEntry} = 2'b00;
	endtask
	task automatic end_sim;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// The sequence needs about 80 cycles; the 10000-cycle limit leaves ample margin.
	initial begin
		#40000;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		check(sprRdata | missVector | tlbWordLo, 32'h0000_0000);
		@(negedge core_clk);
		rst_n = 1;
		for (int k = 0; k < 4; k++) spr(1, tsr_pkg::SPR_SCRATCH0 + 10'(k), 32'h5A5A_0000 + k);
		for (int k = 0; k < 4; k++) rd(tsr_pkg::SPR_SCRATCH0 + 10'(k), 32'h5A5A_0000 + k);
		check(stateOut, stateIn);
		miss(0, 0, 0, EA);
		check(32'(missTaken), 32'h0000_0000);
		userMode = 1;
		spr(1, tsr_pkg::SPR_SCRATCH0, 32'hDEAD_BEEF);
		check(32'(privTrap), 32'h0000_0001);
		rd(tsr_pkg::SPR_SCRATCH0, 32'h0000_0000);
		ld(0);
		check(32'(tlbWrite), 32'h0000_0000);
		userMode = 0;
		rd(tsr_pkg::SPR_SCRATCH0, 32'h5A5A_0000);
		rd(10'h001, 32'h0000_0000);
		configTwo = 32'h0008_0000;
		miss(0, 0, 0, EA);
		check(32'(missTaken), 32'h0000_0001);
		check(missVector, tsr_pkg::VEC_LOAD_MISS);
		check(statusSave & 32'hFC00_FFFF, 32'hA800_5678);
		check(stateOut, 32'h1234_5648);
		// the handler runs with translation off, as the exception left it.
		stateIn = stateOut;
		cw = {1'b1, segmentId, 1'b0, EA[27:22]};
		rd(tsr_pkg::SPR_DATA_MISS, EA);
		rd(tsr_pkg::SPR_DATA_CMP, cw);
		// the search starts at the primary group, then the secondary.
		spr(0, tsr_pkg::SPR_PRIMARY, 32'h0000_0000);
		h1 = sprRdata;
		check(h1 & 32'hFE00_003F, descriptor & 32'hFE00_0000);
		spr(0, tsr_pkg::SPR_SECONDARY, 32'h0000_0000);
		check((h1 ^ sprRdata) & 32'hFE00_003F, 32'h0000_0000);
		spr(1, tsr_pkg::SPR_DATA_MISS, 32'h0000_0000);
		spr(1, tsr_pkg::SPR_PRIMARY, 32'h0000_0000);
		rd(tsr_pkg::SPR_DATA_MISS, EA);
		rd(tsr_pkg::SPR_PRIMARY, h1);
		spr(1, tsr_pkg::SPR_STAGING, 32'hFFFF_FFFF);
		rd(tsr_pkg::SPR_STAGING, 32'hFFFF_F1FB);
		// staging gets the entry's second word, changed bit set.
		spr(1, tsr_pkg::SPR_STAGING, PTE);
		ld(0);
		check(32'({tlbWrite, tlbIsInstr, tlbWay}), 32'h0000_0005);
		check(tlbIndexEa, 32'h0000_7000);
		check(tlbWordHi, cw);
		check(tlbWordLo, PTE & 32'hFFFF_F1FB);
		littleEndian = 1;
		miss(0, 0, 0, 32'h0000_8004);
		littleEndian = 0;
		rd(tsr_pkg::SPR_DATA_MISS, 32'h0000_8003);
		miss(0, 1, 0, EA);
		check(missVector, tsr_pkg::VEC_STORE_MISS);
		// a failed search edits this saved status before its fault.
		check(statusSave & 32'hFC00_0000, 32'hAC00_0000);
		miss(1, 0, 0, IA);
		check(missVector, tsr_pkg::VEC_INSTR_MISS);
		rd(tsr_pkg::SPR_INSTR_MISS, IA);
		cw = {1'b1, segmentId, 1'b0, IA[27:22]};
		rd(tsr_pkg::SPR_INSTR_CMP, cw);
		ld(1);
		check(tlbWordHi, cw);
		check(32'(tlbIsInstr), 32'h0000_0001);
		// a miss with the other way saved must steer the next load there.
		lruWay = 0;
		miss(0, 0, 0, EA);
		ld(0);
		check(32'(tlbWay), 32'h0000_0000);
		lruWay = 1;
		miss(0, 1, 1, EA);
		check(missVector, tsr_pkg::VEC_STORE_MISS);
		@(negedge core_clk);
		anyException = 1;
		@(negedge core_clk);
		anyException = 0;
		check(stateOut, 32'h1234_5648);
		end_sim();
	end
endmodule // tsr_refill_test
